// file: inc/bim_pkg.sv
package bim_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int INSTR_W = 14;
    localparam int PC_W    = 13;
    localparam int LIT_W   = 11;
    localparam int FADDR_W = 7;
    localparam int DATA_W  = 8;
    localparam int LATCH_W = 5;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int LATCH_HI_POS = 4;
    localparam int LATCH_LO_POS = 3;
    localparam int DEST_POS     = 7;

    // ------------------------------------------------------------
    // opcode fields
    // ------------------------------------------------------------
    localparam logic [2:0] JUMP_OP  = 3'h5;
    localparam logic [5:0] INCR_OP  = 6'h0a;
    localparam logic [5:0] SKIP_OP  = 6'h0f;
    localparam logic [5:0] COPY_OP  = 6'h08;
    localparam logic [6:0] STORE_OP = 7'h01;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [PC_W-1:0]   PC_RESET   = 13'h0000;
    localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
    localparam logic              ZERO_RESET = 1'b0;

    // ------------------------------------------------------------
    // decoded operations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BIM_OP_NONE,
        BIM_OP_JUMP,
        BIM_OP_INCR,
        BIM_OP_SKIP,
        BIM_OP_COPY,
        BIM_OP_STORE
    } bim_op_t;

endpackage : bim_pkg

// file: inc/bim_dec_if.sv
`timescale 1ns/1ps
interface bim_dec_if;
    logic [bim_pkg::INSTR_W-1:0] instr;
    bim_pkg::bim_op_t            op;
    logic                        dest;
    logic [bim_pkg::FADDR_W-1:0] faddr;
    logic [bim_pkg::LIT_W-1:0]   literal;

    modport decoder (
        input  instr,
        output op,
        output dest,
        output faddr,
        output literal
    );

    modport core (
        output instr,
        input  op,
        input  dest,
        input  faddr,
        input  literal
    );
endinterface : bim_dec_if

// file: hw/bim_decoder.sv
`timescale 1ns/1ps
module bim_decoder (
    bim_dec_if.decoder dec
);

    // ------------------------------------------------------------
    // opcode match
    // ------------------------------------------------------------
    bim_pkg::bim_op_t op_c;

    always_comb begin
        op_c = bim_pkg::BIM_OP_NONE;
        if (dec.instr[13:11] == bim_pkg::JUMP_OP) begin
            op_c = bim_pkg::BIM_OP_JUMP;
        end else if (dec.instr[13:8] == bim_pkg::INCR_OP) begin
            op_c = bim_pkg::BIM_OP_INCR;
        end else if (dec.instr[13:8] == bim_pkg::SKIP_OP) begin
            op_c = bim_pkg::BIM_OP_SKIP;
        end else if (dec.instr[13:8] == bim_pkg::COPY_OP) begin  // [RQ7]
            op_c = bim_pkg::BIM_OP_COPY;
        end else if (dec.instr[13:7] == bim_pkg::STORE_OP) begin  // [RQ10]
            op_c = bim_pkg::BIM_OP_STORE;
        end
    end

    // ------------------------------------------------------------
    // operand fields
    // ------------------------------------------------------------
    assign dec.op      = op_c;
    assign dec.dest    = dec.instr[bim_pkg::DEST_POS];
    assign dec.faddr   = dec.instr[bim_pkg::FADDR_W-1:0];  // [RQ11]
    assign dec.literal = dec.instr[bim_pkg::LIT_W-1:0];    // [RQ1]

endmodule : bim_decoder

// file: hw/bim_core.sv
`timescale 1ns/1ps
// Summary of operation
// [RQ1] jump loads its 11-bit literal into program counter bits 10 to 0.
// [RQ2] jump fills program counter bits 12 and 11 from latch bits 4 and 3.
// [RQ3] jump takes two cycles and leaves the zero flag alone.
// [RQ4] increment adds one, sets zero flag, writes accumulator (d=0) or register (d=1).
// [RQ5] increment-skip with zero result runs a no-operation next, two cycles, flags kept.
// [RQ6] increment-skip with nonzero result runs the next instruction normally.
// [RQ7] copy decodes from 00 1000 dfff ffff, one word, one cycle.
// [RQ8] copy writes accumulator when d=0, rewrites the same register when d=1.
// [RQ9] copy updates the zero flag from the copied value.
// [RQ10] store writes the accumulator to the register, flags kept, one cycle.
// [RQ11] register operand spans 0 to 127 within the current bank.
module bim_core (
    // clock and reset
    input  wire logic                        sys_clk_i,
    input  wire logic                        srst_i,
    // program memory
    output logic      [bim_pkg::PC_W-1:0]    pc_o,
    input  wire logic [bim_pkg::INSTR_W-1:0] instr_i,
    // upper counter latch
    input  wire logic [bim_pkg::LATCH_W-1:0] upper_counter_latch_i,
    // file register read
    output logic      [bim_pkg::FADDR_W-1:0] file_raddr_o,
    input  wire logic [bim_pkg::DATA_W-1:0]  file_rdata_i,
    // file register write
    output logic                             file_we_o,
    output logic      [bim_pkg::FADDR_W-1:0] file_waddr_o,
    output logic      [bim_pkg::DATA_W-1:0]  file_wdata_o,
    // core state
    output logic      [bim_pkg::DATA_W-1:0]  acc_o,
    output logic                             zero_o,
    output logic                             bubble_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [bim_pkg::PC_W-1:0]    pc;
        logic [bim_pkg::DATA_W-1:0]  acc;
        logic                        zero;
        logic                        bubble;
        logic                        hold;
        logic                        wr_en;
        logic [bim_pkg::FADDR_W-1:0] wr_addr;
        logic [bim_pkg::DATA_W-1:0]  wr_data;
    } bim_state_t;

    localparam bim_state_t STATE_RESET = '{
        pc:      bim_pkg::PC_RESET,
        acc:     bim_pkg::ACC_RESET,
        zero:    bim_pkg::ZERO_RESET,
        bubble:  1'b0,
        hold:    1'b0,
        wr_en:   1'b0,
        wr_addr: '0,
        wr_data: '0
    };

    bim_state_t state_reg;
    bim_state_t state_next;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    bim_dec_if dec ();

    assign dec.instr = instr_i;

    bim_decoder u_decoder (
        .dec (dec)
    );

    // ------------------------------------------------------------
    // operand fetch
    // ------------------------------------------------------------
    logic [bim_pkg::DATA_W-1:0] operand_c;
    logic [bim_pkg::DATA_W-1:0] sum_c;
    logic                       sum_zero_c;
    logic                       fwd_hit_c;

    // the write port lags one cycle; forward it so back-to-back use of
    // the same register sees the new value
    assign fwd_hit_c  = state_reg.wr_en && (state_reg.wr_addr == dec.faddr);
    assign operand_c  = fwd_hit_c ? state_reg.wr_data : file_rdata_i;
    assign sum_c      = operand_c + 8'h01;  // [RQ4]
    assign sum_zero_c = (sum_c == 8'h00);

    logic                       copy_zero_c;

    assign copy_zero_c = (operand_c == 8'h00);  // [RQ9]

    // ------------------------------------------------------------
    // program counter
    // ------------------------------------------------------------
    logic [1:0]                 latch_hi_c;
    logic [bim_pkg::PC_W-1:0]   pc_inc_c;
    logic [bim_pkg::PC_W-1:0]   jump_target_c;

    assign latch_hi_c    = upper_counter_latch_i[bim_pkg::LATCH_HI_POS:bim_pkg::LATCH_LO_POS];  // [RQ2]
    assign jump_target_c = {latch_hi_c, dec.literal};  // [RQ1] [RQ2]
    assign pc_inc_c      = state_reg.pc + 13'h0001;

    // ------------------------------------------------------------
    // discarded slots
    // ------------------------------------------------------------
    logic                       jump_c;
    logic                       skip_taken_c;

    assign jump_c       = (dec.op == bim_pkg::BIM_OP_JUMP);  // [RQ3]
    // nonzero result: the next instruction runs as usual [RQ6]
    assign skip_taken_c = (dec.op == bim_pkg::BIM_OP_SKIP) && sum_zero_c;  // [RQ5]

    // ------------------------------------------------------------
    // result routing
    // ------------------------------------------------------------
    // one result per instruction; the destination bit picks between
    // the accumulator and the addressed register
    logic                       res_valid_c;
    logic [bim_pkg::DATA_W-1:0] res_data_c;
    logic                       res_to_file_c;

    always_comb begin
        res_valid_c   = 1'b0;
        res_data_c    = operand_c;
        res_to_file_c = dec.dest;
        case (dec.op)
            bim_pkg::BIM_OP_INCR,
            bim_pkg::BIM_OP_SKIP: begin
                res_valid_c = 1'b1;
                res_data_c  = sum_c;  // [RQ4]
            end
            bim_pkg::BIM_OP_COPY: begin
                res_valid_c = 1'b1;  // [RQ8]
            end
            bim_pkg::BIM_OP_STORE: begin
                res_valid_c   = 1'b1;
                res_data_c    = state_reg.acc;  // [RQ10]
                res_to_file_c = 1'b1;
            end
            default: begin
                res_valid_c = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // execute
    // ------------------------------------------------------------
    always_comb begin
        state_next       = state_reg;
        state_next.wr_en = 1'b0;
        state_next.pc    = pc_inc_c;

        if (state_reg.bubble) begin
            // discarded slot: nothing is executed
            state_next.bubble = 1'b0;
            state_next.hold   = 1'b0;
            if (state_reg.hold) begin
                state_next.pc = state_reg.pc;  // [RQ3]
            end
        end else begin
            if (res_valid_c && res_to_file_c) begin
                state_next.wr_en   = 1'b1;  // [RQ4] [RQ8] [RQ10]
                state_next.wr_addr = dec.faddr;  // [RQ11]
                state_next.wr_data = res_data_c;
            end else if (res_valid_c) begin
                state_next.acc = res_data_c;  // [RQ4] [RQ8]
            end
            if (jump_c) begin
                state_next.pc     = jump_target_c;  // [RQ1] [RQ2]
                state_next.bubble = 1'b1;  // [RQ3]
                state_next.hold   = 1'b1;
            end
            if (skip_taken_c) begin
                state_next.bubble = 1'b1;  // [RQ5]
                state_next.hold   = 1'b0;
            end
            case (dec.op)
                bim_pkg::BIM_OP_INCR: begin
                    state_next.zero = sum_zero_c;  // [RQ4]
                end
                bim_pkg::BIM_OP_COPY: begin
                    state_next.zero = copy_zero_c;  // [RQ9]
                end
                default: begin
                    // jump, skip, store and unknown words keep the zero flag [RQ3] [RQ5] [RQ10]
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pc_o         = state_reg.pc;
    assign file_raddr_o = dec.faddr;
    assign file_we_o    = state_reg.wr_en;
    assign file_waddr_o = state_reg.wr_addr;
    assign file_wdata_o = state_reg.wr_data;
    assign acc_o        = state_reg.acc;
    assign zero_o       = state_reg.zero;
    assign bubble_o     = state_reg.bubble;

endmodule : bim_core

// file: testbench/bim_mem_model.sv
`timescale 1ns/1ps
module bim_mem_model (
    // clock
    input  wire logic                        sys_clk_i,
    // program memory
    input  wire logic [bim_pkg::PC_W-1:0]    pc_i,
    output logic      [bim_pkg::INSTR_W-1:0] instr_o,
    // file registers
    input  wire logic [bim_pkg::FADDR_W-1:0] raddr_i,
    output logic      [bim_pkg::DATA_W-1:0]  rdata_o,
    input  wire logic                        we_i,
    input  wire logic [bim_pkg::FADDR_W-1:0] waddr_i,
    input  wire logic [bim_pkg::DATA_W-1:0]  wdata_i
);
    logic [bim_pkg::INSTR_W-1:0] prog_mem [0:8191];
    logic [bim_pkg::DATA_W-1:0]  file_mem [0:127];
    // empty words decode as no-ops
    initial begin
        for (int i = 0; i < 8192; i++) prog_mem[i] = 14'h0000;
        for (int i = 0; i < 128; i++) file_mem[i] = 8'h00;
    end
    assign instr_o = prog_mem[pc_i];
    assign rdata_o = file_mem[raddr_i];
    always @(posedge sys_clk_i) begin
        if (we_i) file_mem[waddr_i] <= wdata_i;
    end
endmodule : bim_mem_model

// file: testbench/bim_core_properties.sv
`timescale 1ns/1ps
module bim_core_properties (
    // clock and reset
    input wire logic                        sys_clk_i,
    input wire logic                        srst_i,
    // core ports
    input wire logic [bim_pkg::PC_W-1:0]    pc_o,
    input wire logic [bim_pkg::INSTR_W-1:0] instr_i,
    input wire logic [bim_pkg::LATCH_W-1:0] upper_counter_latch_i,
    input wire logic [bim_pkg::FADDR_W-1:0] file_raddr_o,
    input wire logic [bim_pkg::DATA_W-1:0]  file_rdata_i,
    input wire logic                        file_we_o,
    input wire logic [bim_pkg::FADDR_W-1:0] file_waddr_o,
    input wire logic [bim_pkg::DATA_W-1:0]  file_wdata_o,
    input wire logic [bim_pkg::DATA_W-1:0]  acc_o,
    input wire logic                        zero_o,
    input wire logic                        bubble_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    logic ex, jmp, inc, skp, cpy, sto;
    logic [7:0] opnd;
    // opnd: register value as the core must see it, a pending write forwarded
    assign ex    = !srst_i && !bubble_o;
    assign opnd  = (file_we_o && file_waddr_o == instr_i[6:0]) ? file_wdata_o : file_rdata_i;
    assign jmp   = ex && instr_i[13:11] == bim_pkg::JUMP_OP;
    assign inc   = ex && instr_i[13:8] == bim_pkg::INCR_OP;
    assign skp   = ex && instr_i[13:8] == bim_pkg::SKIP_OP;
    assign cpy   = ex && instr_i[13:8] == bim_pkg::COPY_OP;
    assign sto   = ex && instr_i[13:7] == bim_pkg::STORE_OP;
    AST_JUMP_LOW: assert property (jmp |=> pc_o[10:0] == $past(instr_i[10:0]))
        else $error("jump low bits wrong");
    AST_JUMP_HIGH: assert property (jmp |=> pc_o[12:11] == $past(upper_counter_latch_i[4:3]))
        else $error("jump high bits wrong");
    AST_JUMP_TWO: assert property (jmp |=> bubble_o && $stable(zero_o) ##1 !bubble_o && $stable(pc_o))
        else $error("jump timing wrong");
    AST_INCR: assert property (inc && !instr_i[7] |=> acc_o == 8'($past(opnd) + 8'h01) && zero_o == (acc_o == 8'h00))
        else $error("increment to accumulator wrong");
    AST_INCR_WR: assert property (inc && instr_i[7] |=> file_we_o && file_waddr_o == $past(instr_i[6:0]))
        else $error("increment write wrong");
    AST_SKIP_ZERO: assert property (skp && opnd == 8'hff |=> bubble_o && $stable(zero_o) ##1 !bubble_o)
        else $error("taken skip wrong");
    AST_SKIP_NZ: assert property (skp && opnd != 8'hff |=> !bubble_o && $stable(zero_o))
        else $error("skip inserted wrongly");
    AST_COPY: assert property (cpy && !instr_i[7] |=> acc_o == $past(opnd) && zero_o == (acc_o == 8'h00))
        else $error("copy wrong");
    AST_COPY_WR: assert property (cpy && instr_i[7] |=> file_we_o && file_waddr_o == $past(instr_i[6:0])
        && file_wdata_o == $past(opnd) && zero_o == (file_wdata_o == 8'h00))
        else $error("copy rewrite wrong");
    AST_STORE: assert property (sto |=> file_we_o && file_wdata_o == $past(acc_o) && $stable(zero_o))
        else $error("store wrong");
    COV_JUMP: cover property (jmp ##1 bubble_o);
    COV_SKIP: cover property (skp ##1 bubble_o);
    COV_COPY: cover property (cpy && instr_i[7]);
endmodule : bim_core_properties
bind bim_core bim_core_properties u_bim_core_properties (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .pc_o(pc_o),
    .instr_i(instr_i), .upper_counter_latch_i(upper_counter_latch_i), .file_raddr_o(file_raddr_o),
    .file_rdata_i(file_rdata_i), .file_we_o(file_we_o), .file_waddr_o(file_waddr_o),
    .file_wdata_o(file_wdata_o), .acc_o(acc_o), .zero_o(zero_o), .bubble_o(bubble_o));

// file: testbench/bim_core_bench.sv
`timescale 1ns/1ps
module bim_core_bench;
    logic        sys_clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic [4:0]  latch = 5'h00;
    logic [12:0] pc;
    logic [13:0] instr;
    logic [6:0]  raddr, waddr, a;
    logic [7:0]  rdata, wdata, acc, v;
    logic        we, zero, bubble, sk, ds, d4;
    logic [10:0] k;
    logic [4:0]  lt;
    logic [12:0] tgt;
    logic [15:0] tail;
    int          err_total = 0;
    int          compares = 0;
    int unsigned seed;
    always #50 sys_clk_i = ~sys_clk_i;
    bim_core u_bim_core (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .pc_o(pc), .instr_i(instr),
        .upper_counter_latch_i(latch), .file_raddr_o(raddr), .file_rdata_i(rdata), .file_we_o(we),
        .file_waddr_o(waddr), .file_wdata_o(wdata), .acc_o(acc), .zero_o(zero), .bubble_o(bubble));
    bim_mem_model u_bim_mem_model (.sys_clk_i(sys_clk_i), .pc_i(pc), .instr_o(instr), .raddr_i(raddr),
        .rdata_o(rdata), .we_i(we), .waddr_i(waddr), .wdata_i(wdata));
    function automatic logic [13:0] enc(input logic [5:0] op, input logic d, input logic [6:0] f);
        return {op, d, f};
    endfunction : enc
    function automatic logic [12:0] jump_target(input logic [10:0] kk, input logic [4:0] l);
        return {l[4:3], kk};
    endfunction : jump_target
    // accumulator and register value once the skip and the increment after it have run
    function automatic logic [15:0] skip_tail(input logic [7:0] vv, input logic dsk, input logic dinc);
        logic       taken;
        logic [7:0] s4;
        logic [7:0] acc_v;
        logic [7:0] file_v;
        taken  = (8'(vv + 8'h02) == 8'h00);
        s4     = dsk ? 8'(vv + 8'h03) : 8'(vv + 8'h02);
        acc_v  = dsk ? 8'(vv + 8'h01) : 8'(vv + 8'h02);
        file_v = dsk ? 8'(vv + 8'h02) : 8'(vv + 8'h01);
        if (!taken && !dinc) acc_v = s4;
        if (!taken && dinc) file_v = s4;
        return {acc_v, file_v};
    endfunction : skip_tail
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic reset_check;
        check("reset pc", 16'(pc), 16'h0000);
        check("reset state", 16'({acc, zero, bubble, we}), 16'h0000);
    endtask : reset_check
    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    task automatic tick;
        @(posedge sys_clk_i);
        #1;
    endtask : tick
    initial begin
        repeat (100000) @(posedge sys_clk_i);
        err_total++;
        final_report();
    end
    initial begin
        seed = $urandom(48956);
        repeat (20) @(posedge sys_clk_i);
        #1;
        reset_check();
        for (int it = 0; it < 24; it++) begin
            // first passes hit the wrap to zero and the taken skip
            v = (it == 0) ? 8'hff : (it == 1) ? 8'hfe : (it == 2) ? 8'h00 : 8'($urandom);
            a = 7'($urandom);
            k = 11'(8 + $urandom % 2040);
            lt = 5'($urandom);
            tgt = jump_target(k, lt);
            sk = (8'(v + 8'h02) == 8'h00);
            ds = (it < 2) ? 1'b1 : 1'($urandom);
            d4 = 1'($urandom);
            tail = skip_tail(v, ds, d4);
            u_bim_mem_model.file_mem[a] = v;
            u_bim_mem_model.prog_mem[0] = enc(bim_pkg::COPY_OP, 1'b0, a);
            u_bim_mem_model.prog_mem[1] = enc(bim_pkg::INCR_OP, 1'b0, a);
            u_bim_mem_model.prog_mem[2] = {bim_pkg::STORE_OP, a};
            u_bim_mem_model.prog_mem[3] = enc(bim_pkg::SKIP_OP, ds, a);
            u_bim_mem_model.prog_mem[4] = enc(bim_pkg::INCR_OP, d4, a);
            u_bim_mem_model.prog_mem[5] = {bim_pkg::JUMP_OP, k};
            u_bim_mem_model.prog_mem[tgt] = enc(bim_pkg::COPY_OP, 1'b1, a);
            @(posedge sys_clk_i) begin
                srst_i <= 1'b0;
                latch <= lt;
            end
            tick();
            check("copy acc", 16'(acc), 16'(v));
            check("copy zero", 16'(zero), 16'(v == 8'h00));
            tick();
            check("incr acc", 16'(acc), 16'(8'(v + 8'h01)));
            check("incr zero", 16'(zero), 16'(8'(v + 8'h01) == 8'h00));
            tick();
            tick();
            check("skip bubble", 16'(bubble), 16'(sk));
            check("skip zero", 16'(zero), 16'(8'(v + 8'h01) == 8'h00));
            tick();
            tick();
            check("jump low", 16'(pc[10:0]), 16'(k));
            check("jump high", 16'(pc[12:11]), 16'(lt[4:3]));
            check("jump bubble", 16'(bubble), 16'h0001);
            tick();
            check("jump hold", 16'({pc, bubble}), 16'({tgt, 1'b0}));
            check("skip result", 16'(acc), 16'(tail[15:8]));
            tick();
            check("rewrite zero", 16'(zero), 16'(tail[7:0] == 8'h00));
            check("file value", 16'(u_bim_mem_model.file_mem[a]), 16'(tail[7:0]));
            @(posedge sys_clk_i) srst_i <= 1'b1;
            tick();
            reset_check();
            u_bim_mem_model.prog_mem[tgt] = 14'h0000;
            $display("test %0d done", it);
        end
        final_report();
    end
endmodule : bim_core_bench
